// ### rtl/ipc_pkg.sv
package ipc_pkg;
	// ------------------------------------------------------------
	// Register byte offsets
	// ------------------------------------------------------------
	localparam logic [7:0] OFS_VECTOR = 8'h00;
	localparam logic [7:0] OFS_LEVEL = 8'h04;
	localparam logic [7:0] OFS_REQ = 8'h08;
	localparam logic [7:0] OFS_EDGE = 8'h0C;
	localparam logic [7:0] OFS_PMODE2 = 8'h10;
	localparam logic [7:0] OFS_CPUFLAG = 8'h14;
	localparam logic [7:0] OFS_KEYDIR = 8'h18;
	localparam logic [7:0] OFS_MATCH_EN = 8'h1C;
	localparam logic [7:0] OFS_MATCH0 = 8'h20;
	localparam logic [7:0] OFS_MATCH1 = 8'h24;
	localparam logic [7:0] OFS_MATCH2 = 8'h28;
	localparam logic [7:0] OFS_MATCH3 = 8'h2C;
	localparam logic [7:0] OFS_SPECIAL = 8'h30;
	localparam logic [7:0] OFS_ISP = 8'h34;
	localparam logic [7:0] OFS_USP = 8'h38;
	// ------------------------------------------------------------
	// Field positions and reset values
	// ------------------------------------------------------------
	localparam int POS_IPL = 4;
	localparam int POS_VEC_LVL = 8;
	localparam int POS_EXT4_ROUTE = 6;
	localparam int POS_EXT5_ROUTE = 7;
	localparam logic [15:0] RST_STACK_PTR = 16'h0000;
	localparam logic [2:0] RST_IPL = 3'h0;
	localparam logic [2:0] IPL_SPECIAL = 3'h7;
	localparam logic [2:0] LVL_OFF = 3'h0;
	// ------------------------------------------------------------
	// Source kinds and vector numbers
	// ------------------------------------------------------------
	localparam logic [2:0] KIND_SWI = 3'h0;
	localparam logic [2:0] KIND_MATCH = 3'h1;
	localparam logic [2:0] KIND_NMI = 3'h2;
	localparam logic [2:0] KIND_SHARED = 3'h3;
	localparam logic [2:0] KIND_MASK = 3'h4;
	localparam logic [5:0] VEC_MATCH = 6'h01;
	localparam logic [5:0] VEC_NMI = 6'h02;
	localparam logic [5:0] VEC_SHARED = 6'h03;
	localparam logic [5:0] VEC_MASK_BASE = 6'h10;
	localparam logic [19:0] PC_STEP_SHORT = 20'h00002;
	localparam logic [19:0] PC_STEP_LONG = 20'h00001;
	// ------------------------------------------------------------
	// Accepted interrupt descriptor
	// ------------------------------------------------------------
	typedef struct packed {
		logic [2:0] kind;
		logic [5:0] num;
		logic [2:0] lvl;
		logic [19:0] pc;
	} ipc_take_t;
endpackage : ipc_pkg

// ### rtl/ipc_top.sv
// Operation
// [R1] Only highest priority request accepted per sample
// [R2] Maskable priority from level; fixed order breaks ties
// [R3] Special sources have fixed hardware priority
// [R4] Software interrupt always branches to handler
// [R5] Accept clears enable, request, loads level
// [R6] Re-enabled handler accepts strictly higher levels
// [R7] Rejected requests pend; retried after return
// [R8] Six external inputs edge triggered, selectable polarity
// [R9] Software routes inputs four, five via bits
// [R10] Falling nonmaskable pin fires, ignores enable, level
// [R11] Nonmaskable pin active only once enabled
// [R12] Nonmaskable pin debounced before edge detection
// [R13] Low input key pin sets key request
// [R14] Key pins wired; held low masks others
// [R15] Key request wakes from wait, stop
// [R16] Four enabled address compares fire before instruction
// [R17] Address match ignores enable flag, level
// [R18] Match stacked PC plus two or one
// [R19] Three specials share vector, readable detect flags
// [R20] Vector read returns info, clears best request
// [R21] Both stack pointers reset to zero
// [R22] First instruction after reset blocks all interrupts
// [R23] Maskable needs enable, request, level above current
// [R24] Level zero disables; one to seven rising
// [R25] Nonmaskable and shared specials set level seven
// [R26] Fixed order table, lower index wins ties
`timescale 1ns/1ps
module ipc_top import ipc_pkg::*; #(
	parameter int NUM_MASK = 8,
	parameter int DEB_CYCLES = 8
) (
	input wire logic CLK_I, // Core clock
	input wire logic SYS_RST_I, // Async reset, high
	input wire logic PSEL_I, // APB select
	input wire logic PENABLE_I, // APB enable
	input wire logic PWRITE_I, // APB direction
	input wire logic [7:0] PADDR_I, // APB address
	input wire logic [31:0] PWDATA_I, // APB write data
	output logic [31:0] PRDATA_O, // APB read data
	output logic PREADY_O, // APB ready
	output logic PSLVERR_O, // APB error
	input wire logic [5:0] EXT_IRQ_I, // External interrupt pins
	input wire logic NMI_N_I, // Nonmaskable pin, low active
	input wire logic [3:0] KEY_N_I, // Key pins, low active
	input wire logic PERIPH_REQ_I, // Peripheral event pulse
	input wire logic WDT_EVT_I, // Watchdog underflow pulse
	input wire logic OSC_EVT_I, // Oscillator stop pulse
	input wire logic VOLT_EVT_I, // Voltage pass pulse
	input wire logic CPU_SAMPLE_I, // Instruction boundary pulse
	input wire logic [19:0] CPU_PC_I, // Next fetch address
	input wire logic CPU_SHORT_I, // Next op is short immediate
	input wire logic SWI_I, // Software interrupt at sample
	input wire logic [5:0] SWI_NUM_I, // Software interrupt number
	input wire logic RETURN_FROM_IRQ_INSTR_I, // Return restores flags
	input wire logic RETURN_FROM_IRQ_INSTR_IFLAG_I, // Restored enable flag
	input wire logic [2:0] RETURN_FROM_IRQ_INSTR_IPL_I, // Restored priority level
	output logic TAKE_O, // Accept pulse
	output ipc_take_t INFO_O, // Accepted descriptor
	output logic IFLAG_O, // Global enable flag
	output logic [2:0] IPL_O, // Processor priority level
	output logic WAKE_O // Wake request pulse
);
	// ------------------------------------------------------------
	// State
	// ------------------------------------------------------------
	logic [3*NUM_MASK-1:0] level_reg;
	logic [NUM_MASK-1:0] req;
	logic [7:0] edge_sel;
	logic nmi_en;
	logic nmi_en_d;
	logic iflag;
	logic [2:0] processor_priority_level;
	logic [3:0] key_dir;
	logic [3:0] match_en;
	logic [19:0] match_addr [4];
	logic [2:0] special;
	logic [15:0] interrupt_stack_pointer;
	logic [15:0] user_stack_pointer;
	logic first_ok;
	logic nmi_pend;
	logic shared_pend;
	logic [5:0] e_s1, e_s2, e_s3;
	logic [2:0] ext_fill;
	logic [3:0] k_s1, k_s2;
	logic key_low_d;
	logic n_s1, n_s2, filt, filt_d;
	logic [$clog2(DEB_CYCLES+1)-1:0] deb_cnt;

	// ------------------------------------------------------------
	// APB decode
	// ------------------------------------------------------------
	wire apb_acc = PSEL_I & PENABLE_I;
	wire apb_done = apb_acc & PREADY_O;
	wire wr = apb_done & PWRITE_I;
	wire rd = apb_done & ~PWRITE_I;
	wire wr_level = wr && PADDR_I == OFS_LEVEL;
	wire wr_req = wr && PADDR_I == OFS_REQ;
	wire wr_edge = wr && PADDR_I == OFS_EDGE;
	wire wr_pm2 = wr && PADDR_I == OFS_PMODE2;
	wire wr_flag = wr && PADDR_I == OFS_CPUFLAG;
	wire wr_kdir = wr && PADDR_I == OFS_KEYDIR;
	wire wr_men = wr && PADDR_I == OFS_MATCH_EN;
	wire wr_spec = wr && PADDR_I == OFS_SPECIAL;
	wire wr_isp = wr && PADDR_I == OFS_ISP;
	wire wr_usp = wr && PADDR_I == OFS_USP;
	wire rd_vec = rd && PADDR_I == OFS_VECTOR;

	// ------------------------------------------------------------
	// Source detection
	// ------------------------------------------------------------
	// Edge select per pin, routing bits gate inputs four and five
	wire [5:0] rise = e_s2 & ~e_s3;
	wire [5:0] fall = ~e_s2 & e_s3;
	wire [5:0] edge_hit = (edge_sel[5:0] & rise) | (~edge_sel[5:0] & fall); // R8
	wire [5:0] route = {edge_sel[POS_EXT5_ROUTE], edge_sel[POS_EXT4_ROUTE], 4'hF}; // R9
	// Edges count only once every stage holds a real pin sample, so reset leaves no false edge
	wire [5:0] ext_ev = edge_hit & route & {6{ext_fill[2]}};
	// Key pins form one wired low; only the first low counts
	wire key_low = |(~k_s2 & ~key_dir); // R13
	wire key_ev = key_low & ~key_low_d; // R14
	// Falling filtered pin, or enabling while already low
	wire nmi_ev = nmi_en & ~filt & (filt_d | ~nmi_en_d); // R10 R11
	wire [NUM_MASK-1:0] set_ev = NUM_MASK'({PERIPH_REQ_I, key_ev, ext_ev});
	wire [2:0] spec_ev = {VOLT_EVT_I, OSC_EVT_I, WDT_EVT_I};

	// ------------------------------------------------------------
	// Arbitration
	// ------------------------------------------------------------
	logic [2:0] lvl_f [NUM_MASK];
	logic [2:0] best_idx, any_idx, m_idx;
	logic [2:0] best_lvl, any_lvl;
	logic [3:0] m_hit;
	genvar g;
	generate
		for (g = 0; g < NUM_MASK; g++) begin : g_lvl
			assign lvl_f[g] = level_reg[3*g +: 3];
		end
		for (g = 0; g < 4; g++) begin : g_cmp
			assign m_hit[g] = match_en[g] && match_addr[g] == CPU_PC_I; // R16
		end
	endgenerate

	// Highest level pending source; downward scan lets low index win ties
	always_comb begin
		best_idx = 3'h0;
		best_lvl = LVL_OFF;
		m_idx = 3'h0;
		for (int i = NUM_MASK - 1; i >= 0; i--) begin
			if (req[i] && lvl_f[i] != LVL_OFF && lvl_f[i] >= best_lvl) begin // R2 R24 R26
				best_idx = 3'(i);
				best_lvl = lvl_f[i];
			end
		end
		for (int i = 3; i >= 0; i--) begin
			if (m_hit[i]) begin // R26
				m_idx = 3'(i);
			end
		end
	end
	assign any_idx = best_idx;
	assign any_lvl = best_lvl;

	// Fixed order: software, address match, pin, shared vector, maskable
	wire samp = CPU_SAMPLE_I & first_ok; // R22
	wire hit_match = |m_hit;
	wire take_swi = samp & SWI_I; // R4
	wire take_match = samp & ~SWI_I & hit_match; // R3 R17
	wire pre_nmi = samp & ~SWI_I & ~hit_match;
	wire take_nmi = pre_nmi & nmi_pend; // R3 R10
	wire take_shr = pre_nmi & ~nmi_pend & shared_pend; // R3
	wire mask_ok = iflag && best_lvl > processor_priority_level; // R6 R7 R23
	wire take_mask = pre_nmi & ~nmi_pend & ~shared_pend & mask_ok; // R1
	wire any_take = take_swi | take_match | take_nmi | take_shr | take_mask;

	wire [2:0] t_kind = take_swi ? KIND_SWI : take_match ? KIND_MATCH :
		take_nmi ? KIND_NMI : take_shr ? KIND_SHARED : KIND_MASK;
	wire [5:0] t_num = take_swi ? SWI_NUM_I : take_match ? VEC_MATCH + 6'(m_idx) :
		take_nmi ? VEC_NMI : take_shr ? VEC_SHARED : VEC_MASK_BASE + 6'(best_idx);
	wire [2:0] t_lvl = (take_nmi | take_shr) ? IPL_SPECIAL : take_mask ? best_lvl : processor_priority_level;
	wire [19:0] t_pc = take_match ? CPU_PC_I + (CPU_SHORT_I ? PC_STEP_SHORT : PC_STEP_LONG) : CPU_PC_I; // R18
	wire ipc_take_t next_info = '{kind: t_kind, num: t_num, lvl: t_lvl, pc: t_pc};
	// Level loads on maskable and level seven special accepts, on return and on flag write
	wire [2:0] next_ipl = (take_nmi | take_shr) ? IPL_SPECIAL : take_mask ? best_lvl : // R25
		RETURN_FROM_IRQ_INSTR_I ? RETURN_FROM_IRQ_INSTR_IPL_I : wr_flag ? PWDATA_I[POS_IPL +: 3] : processor_priority_level; // R7
	wire next_iflag = any_take ? 1'b0 : RETURN_FROM_IRQ_INSTR_I ? RETURN_FROM_IRQ_INSTR_IFLAG_I : wr_flag ? PWDATA_I[0] : iflag; // R5 R6

	// Request flags: set beats every clear
	wire [NUM_MASK-1:0] clr_wr = wr_req ? ~PWDATA_I[NUM_MASK-1:0] : '0;
	wire [NUM_MASK-1:0] clr_take = take_mask ? NUM_MASK'(1) << best_idx : '0; // R5
	wire [NUM_MASK-1:0] clr_vec = (rd_vec && any_lvl != LVL_OFF) ? NUM_MASK'(1) << any_idx : '0; // R20
	wire [NUM_MASK-1:0] next_req = (req & ~(clr_wr | clr_take | clr_vec)) | set_ev;
	wire [2:0] next_special = (special & ~(wr_spec ? ~PWDATA_I[2:0] : 3'h0)) | spec_ev; // R19

	// ------------------------------------------------------------
	// Read mux
	// ------------------------------------------------------------
	wire [31:0] vec_word = {21'h0, any_lvl, 2'h0, VEC_MASK_BASE + 6'(any_idx)}; // R20
	wire hit_addr = PADDR_I == OFS_VECTOR || PADDR_I == OFS_LEVEL || PADDR_I == OFS_REQ ||
		PADDR_I == OFS_EDGE || PADDR_I == OFS_PMODE2 || PADDR_I == OFS_CPUFLAG ||
		PADDR_I == OFS_KEYDIR || PADDR_I == OFS_MATCH_EN || PADDR_I == OFS_MATCH0 ||
		PADDR_I == OFS_MATCH1 || PADDR_I == OFS_MATCH2 || PADDR_I == OFS_MATCH3 ||
		PADDR_I == OFS_SPECIAL || PADDR_I == OFS_ISP || PADDR_I == OFS_USP;
	wire [31:0] rd_val =
		PADDR_I == OFS_VECTOR ? vec_word :
		PADDR_I == OFS_LEVEL ? 32'(level_reg) :
		PADDR_I == OFS_REQ ? 32'(req) :
		PADDR_I == OFS_EDGE ? {24'h0, edge_sel} :
		PADDR_I == OFS_PMODE2 ? {31'h0, nmi_en} :
		PADDR_I == OFS_CPUFLAG ? {25'h0, processor_priority_level, 3'h0, iflag} :
		PADDR_I == OFS_KEYDIR ? {28'h0, key_dir} :
		PADDR_I == OFS_MATCH_EN ? {28'h0, match_en} :
		PADDR_I == OFS_MATCH0 ? {12'h0, match_addr[0]} :
		PADDR_I == OFS_MATCH1 ? {12'h0, match_addr[1]} :
		PADDR_I == OFS_MATCH2 ? {12'h0, match_addr[2]} :
		PADDR_I == OFS_MATCH3 ? {12'h0, match_addr[3]} :
		PADDR_I == OFS_SPECIAL ? {29'h0, special} :
		PADDR_I == OFS_ISP ? {16'h0, interrupt_stack_pointer} :
		PADDR_I == OFS_USP ? {16'h0, user_stack_pointer} : 32'h0000_0000;

	// ------------------------------------------------------------
	// APB slave: one wait state, response registered
	// ------------------------------------------------------------
	always_ff @(posedge CLK_I or posedge SYS_RST_I) begin
		if (SYS_RST_I) begin
			PREADY_O <= 1'b0;
			PRDATA_O <= 32'h0000_0000;
			PSLVERR_O <= 1'b0;
		end else begin
			PREADY_O <= apb_acc & ~PREADY_O;
			PRDATA_O <= (apb_acc & ~PREADY_O & ~PWRITE_I) ? rd_val : 32'h0000_0000;
			PSLVERR_O <= apb_acc & ~PREADY_O & ~hit_addr;
		end
	end

	// Software configuration registers
	always_ff @(posedge CLK_I or posedge SYS_RST_I) begin
		if (SYS_RST_I) begin
			level_reg <= '0;
			edge_sel <= 8'h00;
			nmi_en <= 1'b0;
			key_dir <= 4'h0;
			match_en <= 4'h0;
			interrupt_stack_pointer <= RST_STACK_PTR; // R21
			user_stack_pointer <= RST_STACK_PTR; // R21
		end else begin
			if (wr_level) level_reg <= PWDATA_I[3*NUM_MASK-1:0];
			if (wr_edge) edge_sel <= PWDATA_I[7:0];
			if (wr_pm2 && PWDATA_I[0]) nmi_en <= 1'b1; // R11
			if (wr_kdir) key_dir <= PWDATA_I[3:0];
			if (wr_men) match_en <= PWDATA_I[3:0];
			if (wr_isp) interrupt_stack_pointer <= PWDATA_I[15:0];
			if (wr_usp) user_stack_pointer <= PWDATA_I[15:0];
		end
	end

	// Match address registers
	always_ff @(posedge CLK_I or posedge SYS_RST_I) begin
		if (SYS_RST_I) begin
			for (int i = 0; i < 4; i++) match_addr[i] <= 20'h00000;
		end else begin
			for (int i = 0; i < 4; i++) begin
				if (wr && PADDR_I == OFS_MATCH0 + 8'(4 * i)) match_addr[i] <= PWDATA_I[19:0];
			end
		end
	end

	// ------------------------------------------------------------
	// Pin synchronisers and debounce
	// ------------------------------------------------------------
	always_ff @(posedge CLK_I or posedge SYS_RST_I) begin
		if (SYS_RST_I) begin
			e_s1 <= 6'h3F;
			e_s2 <= 6'h3F;
			e_s3 <= 6'h3F;
			ext_fill <= 3'h0;
			k_s1 <= 4'hF;
			k_s2 <= 4'hF;
			key_low_d <= 1'b0;
			n_s1 <= 1'b1;
			n_s2 <= 1'b1;
		end else begin
			e_s1 <= EXT_IRQ_I;
			e_s2 <= e_s1;
			e_s3 <= e_s2;
			ext_fill <= {ext_fill[1:0], 1'b1};
			k_s1 <= KEY_N_I;
			k_s2 <= k_s1;
			key_low_d <= key_low;
			n_s1 <= NMI_N_I;
			n_s2 <= n_s1;
		end
	end

	// Filter follows the pin only after it holds for the debounce count
	always_ff @(posedge CLK_I or posedge SYS_RST_I) begin
		if (SYS_RST_I) begin
			filt <= 1'b1;
			filt_d <= 1'b1;
			deb_cnt <= '0;
			nmi_en_d <= 1'b0;
		end else begin
			filt_d <= filt;
			nmi_en_d <= nmi_en;
			if (n_s2 == filt) begin
				deb_cnt <= '0;
			end else if (deb_cnt == $bits(deb_cnt)'(DEB_CYCLES - 1)) begin // R12
				filt <= n_s2;
				deb_cnt <= '0;
			end else begin
				deb_cnt <= deb_cnt + 1'b1;
			end
		end
	end

	// ------------------------------------------------------------
	// Pending state, flags and accept outputs
	// ------------------------------------------------------------
	always_ff @(posedge CLK_I or posedge SYS_RST_I) begin
		if (SYS_RST_I) begin
			req <= '0;
			special <= 3'h0;
			nmi_pend <= 1'b0;
			shared_pend <= 1'b0;
			first_ok <= 1'b0;
			iflag <= 1'b0;
			processor_priority_level <= RST_IPL;
		end else begin
			req <= next_req; // R7
			special <= next_special;
			nmi_pend <= nmi_ev | (nmi_pend & ~take_nmi);
			shared_pend <= (|spec_ev) | (shared_pend & ~take_shr);
			if (CPU_SAMPLE_I) first_ok <= 1'b1; // R22
			iflag <= next_iflag;
			processor_priority_level <= next_ipl;
		end
	end

	// Registered copies of the accept result for the sequencer
	always_ff @(posedge CLK_I or posedge SYS_RST_I) begin
		if (SYS_RST_I) begin
			TAKE_O <= 1'b0;
			INFO_O <= '0;
			IFLAG_O <= 1'b0;
			IPL_O <= RST_IPL;
			WAKE_O <= 1'b0;
		end else begin
			TAKE_O <= any_take;
			if (any_take) INFO_O <= next_info;
			IFLAG_O <= next_iflag;
			IPL_O <= next_ipl;
			WAKE_O <= key_ev; // R15
		end
	end

	// ------------------------------------------------------------
	// Assertions
	// ------------------------------------------------------------
	default clocking cb @(posedge CLK_I); endclocking
	default disable iff (SYS_RST_I);

	a_first_block: assert property (CPU_SAMPLE_I && !first_ok |=> !TAKE_O) // R22
		else $error("accept during first instruction");
	a_swi_always: assert property (samp && SWI_I |=> TAKE_O && INFO_O.kind == KIND_SWI) // R4
		else $error("software interrupt not taken");
	a_enter_flags: assert property (TAKE_O |-> !IFLAG_O) // R5
		else $error("enable flag not cleared on entry");
	a_mask_gate: assert property (TAKE_O && INFO_O.kind == KIND_MASK |-> // R23
		$past(iflag) && INFO_O.lvl > $past(processor_priority_level) && IPL_O == INFO_O.lvl)
		else $error("maskable accepted without enable or level");
	a_lvl_nonzero: assert property (TAKE_O && INFO_O.kind == KIND_MASK |-> INFO_O.lvl != LVL_OFF) // R24
		else $error("level zero source accepted");
	a_special_ipl: assert property (TAKE_O && (INFO_O.kind == KIND_NMI || INFO_O.kind == KIND_SHARED) |->
		IPL_O == IPL_SPECIAL) // R25
		else $error("special did not raise level to seven");
	a_match_pc: assert property (TAKE_O && INFO_O.kind == KIND_MATCH |->
		INFO_O.pc == $past(CPU_PC_I) + ($past(CPU_SHORT_I) ? PC_STEP_SHORT : PC_STEP_LONG)) // R18
		else $error("wrong stacked match address");
	a_match_any: assert property (samp && !SWI_I && hit_match |=> TAKE_O && INFO_O.kind == KIND_MATCH) // R17
		else $error("address match not taken");
	a_req_clear: assert property (take_mask && !set_ev[best_idx] |=> !req[$past(best_idx)]) // R5
		else $error("accepted request not cleared");
	a_nmi_gate: assert property (!nmi_en |=> !nmi_pend || $past(nmi_pend)) // R11
		else $error("pin interrupt raised while disabled");
	a_key_wake: assert property (key_ev |=> WAKE_O ##1 !WAKE_O || key_ev) // R15
		else $error("key event did not wake");
	a_apb_ready: assert property (apb_acc && !PREADY_O |=> PREADY_O)
		else $error("slave did not answer");

	c_mask_take: cover property (TAKE_O && INFO_O.kind == KIND_MASK);
	c_nested: cover property (TAKE_O && INFO_O.kind == KIND_MASK ##[1:50] TAKE_O && INFO_O.kind == KIND_MASK);
	c_match_take: cover property (TAKE_O && INFO_O.kind == KIND_MATCH);
	c_nmi_take: cover property (TAKE_O && INFO_O.kind == KIND_NMI);
endmodule : ipc_top

// ### tb/ipc_cpu_model.sv
`timescale 1ns/1ps
// ------------------------------------------------------------
// CPU sequencer stand-in: sampling points and returns
// ------------------------------------------------------------
module ipc_cpu_model (
	input wire logic clk_i, // Core clock
	output logic sample_o, // Sampling point pulse
	output logic [19:0] pc_o, // Next fetch address
	output logic short_o, // Short immediate form
	output logic swi_o, // Software interrupt
	output logic [5:0] swi_num_o, // Its number
	output logic return_from_irq_instr_o, // Return pulse
	output logic return_from_irq_instr_iflag_o, // Restored enable flag
	output logic [2:0] return_from_irq_instr_ipl_o // Restored level
);
	// Idle values at time zero
	initial begin
		{sample_o, swi_o, return_from_irq_instr_o, return_from_irq_instr_iflag_o} = 4'h0;
		{pc_o, short_o, swi_num_o, return_from_irq_instr_ipl_o} = 30'h2AAAAAAA;
	end
	// One sampling point; address, form and number show their inverse outside it and the software flag drops, so stale values never match
	task do_sample(input logic [19:0] p, input logic sh, input logic sw, input logic [5:0] n);
		sample_o <= 1'b1;
		{pc_o, short_o, swi_o, swi_num_o} <= {p, sh, sw, n};
		@(posedge clk_i);
		sample_o <= 1'b0;
		{pc_o, short_o, swi_o, swi_num_o} <= {~p, ~sh, 1'b0, ~n};
	endtask : do_sample
	// Return instruction restoring flag and level
	task do_return_from_irq_instr(input logic f, input logic [2:0] l);
		{return_from_irq_instr_o, return_from_irq_instr_iflag_o, return_from_irq_instr_ipl_o} <= {1'b1, f, l};
		@(posedge clk_i);
		{return_from_irq_instr_o, return_from_irq_instr_iflag_o, return_from_irq_instr_ipl_o} <= {1'b0, ~f, ~l};
	endtask : do_return_from_irq_instr
endmodule : ipc_cpu_model

// ### tb/testbench.sv
`timescale 1ns/1ps
`define CHK(n, e, a) begin total_checks++; if ((a) !== (e)) begin miscompares++; \
	$display("CHECK FAILED %s exp %0h got %0h", n, e, a); end end
module testbench import ipc_pkg::*;;
	logic clk, rst, psel, pen, pwr, pready, pslverr, nmi_n, periph, wdt, osc, volt;
	logic sample, short_op, swi, return_from_irq_instr, return_from_irq_instr_f, take, iflag, wake, e;
	logic [7:0] paddr;
	logic [31:0] pwdata, prdata, q;
	logic [5:0] ext, swi_num;
	logic [3:0] key_n;
	logic [19:0] pc;
	logic [2:0] return_from_irq_instr_l, processor_priority_level;
	ipc_take_t info;
	int miscompares = 0;
	int total_checks = 0;
	ipc_top #(.DEB_CYCLES(4)) ipc_top_inst (.CLK_I(clk), .SYS_RST_I(rst), .PSEL_I(psel), .PENABLE_I(pen),
		.PWRITE_I(pwr), .PADDR_I(paddr), .PWDATA_I(pwdata), .PRDATA_O(prdata), .PREADY_O(pready),
		.PSLVERR_O(pslverr), .EXT_IRQ_I(ext), .NMI_N_I(nmi_n), .KEY_N_I(key_n), .PERIPH_REQ_I(periph),
		.WDT_EVT_I(wdt), .OSC_EVT_I(osc), .VOLT_EVT_I(volt), .CPU_SAMPLE_I(sample), .CPU_PC_I(pc),
		.CPU_SHORT_I(short_op), .SWI_I(swi), .SWI_NUM_I(swi_num), .RETURN_FROM_IRQ_INSTR_I(return_from_irq_instr), .RETURN_FROM_IRQ_INSTR_IFLAG_I(return_from_irq_instr_f),
		.RETURN_FROM_IRQ_INSTR_IPL_I(return_from_irq_instr_l), .TAKE_O(take), .INFO_O(info), .IFLAG_O(iflag), .IPL_O(processor_priority_level), .WAKE_O(wake));
	ipc_cpu_model ipc_cpu_model_inst (.clk_i(clk), .sample_o(sample), .pc_o(pc), .short_o(short_op),
		.swi_o(swi), .swi_num_o(swi_num), .return_from_irq_instr_o(return_from_irq_instr), .return_from_irq_instr_iflag_o(return_from_irq_instr_f), .return_from_irq_instr_ipl_o(return_from_irq_instr_l));
	// ------------------------------------------------------------
	// Helpers
	// ------------------------------------------------------------
	task close_out;
		if (miscompares == 0 && total_checks > 0)
			$display("NO MISMATCHES");
		else
			$display("MISMATCHES SEEN");
		$finish;
	endtask : close_out
	// APB transfer; ready, read data and error are taken at the rising edge that samples ready high
	task apb(input logic w, input logic [7:0] a, input logic [31:0] d);
		int n;
		n = 0;
		{psel, pen, pwr, paddr, pwdata} <= {2'b10, w, a, d};
		@(posedge clk);
		pen <= 1'b1;
		@(posedge clk);
		while (pready !== 1'b1) begin
			n++;
			if (n > 16) begin
				miscompares++;
				close_out();
			end
			@(posedge clk);
		end
		{q, e} = {prdata, pslverr};
		{psel, pen} <= 2'b00;
		// One idle edge keeps the next setup from reassigning select in this time step
		@(posedge clk);
	endtask : apb
	task wr(input logic [7:0] a, input logic [31:0] d);
		apb(1'b1, a, d);
	endtask : wr
	task rd(input logic [7:0] a, input logic [31:0] x);
		apb(1'b0, a, 32'h0);
		`CHK($sformatf("reg %0h", a), x, q)
	endtask : rd
	// One sampling point and the accept that follows it
	task samp(input logic [19:0] p, input logic sh, input logic sw, input logic [5:0] n, input logic t,
		input logic [2:0] k, input logic [5:0] num, input logic [2:0] l);
		ipc_cpu_model_inst.do_sample(p, sh, sw, n);
		#1;
		`CHK("take", t, take)
		if (t) begin
			`CHK("kind", k, info.kind)
			`CHK("num", num, info.num)
			`CHK("ipl", l, processor_priority_level)
			`CHK("iflag", 1'b0, iflag)
			`CHK("pc", (k === KIND_MATCH) ? p + (sh ? PC_STEP_SHORT : PC_STEP_LONG) : p, info.pc)
		end
		@(posedge clk);
	endtask : samp
	task wakes(input int x);
		int c;
		c = 0;
		repeat (8) begin
			@(negedge clk);
			if (wake !== 1'b0)
				c++;
		end
		`CHK("wake", x, c)
		@(posedge clk);
	endtask : wakes
	// ------------------------------------------------------------
	// Scenarios
	// ------------------------------------------------------------
	task t_mask;
		wr(OFS_LEVEL, 32'h00A0001B);
		wr(OFS_EDGE, 32'h000000FF);
		wr(OFS_REQ, 32'h0);
		wr(OFS_CPUFLAG, 32'h01);
		ext <= 6'h07;
		periph <= 1'b1;
		@(posedge clk);
		periph <= 1'b0;
		repeat (5) @(posedge clk);
		rd(OFS_REQ, 32'h87);
		samp(20'h00300, 0, 0, 0, 1, KIND_MASK, VEC_MASK_BASE + 6'd7, 3'd5);
		rd(OFS_REQ, 32'h07);
		wr(OFS_CPUFLAG, 32'h51);
		samp(20'h00304, 0, 0, 0, 0, 0, 0, 0);
		wr(OFS_CPUFLAG, 32'h21);
		samp(20'h00308, 0, 0, 0, 1, KIND_MASK, VEC_MASK_BASE, 3'd3);
		ipc_cpu_model_inst.do_return_from_irq_instr(1'b1, 3'd3);
		samp(20'h0030C, 0, 0, 0, 0, 0, 0, 0);
		ipc_cpu_model_inst.do_return_from_irq_instr(1'b1, 3'd2);
		samp(20'h00310, 0, 0, 0, 1, KIND_MASK, VEC_MASK_BASE + 6'd1, 3'd3);
		rd(OFS_REQ, 32'h04);
		ipc_cpu_model_inst.do_return_from_irq_instr(1'b1, 3'd0);
		samp(20'h00314, 0, 0, 0, 0, 0, 0, 0);
		wr(OFS_LEVEL, 32'h00A0019B);
		rd(OFS_VECTOR, 32'h612);
		rd(OFS_REQ, 32'h0);
		// Falling polarity on all pins, input four unrouted, input five routed
		wr(OFS_EDGE, 32'h00000080);
		ext <= 6'h37;
		repeat (4) @(posedge clk);
		ext <= 6'h00;
		repeat (4) @(posedge clk);
		rd(OFS_REQ, 32'h27);
		wr(OFS_REQ, 32'h0);
	endtask : t_mask
	task t_swi_match;
		wr(OFS_CPUFLAG, 32'h70);
		samp(20'h00400, 0, 1, 6'h05, 1, KIND_SWI, 6'h05, 3'd7);
		wr(OFS_MATCH0, 32'h0ABCD);
		wr(OFS_MATCH2, 32'h12345);
		wr(OFS_MATCH_EN, 32'h5);
		samp(20'h12345, 1, 0, 0, 1, KIND_MATCH, VEC_MATCH + 6'd2, 3'd7);
		samp(20'h0ABCD, 0, 0, 0, 1, KIND_MATCH, VEC_MATCH, 3'd7);
		wr(OFS_MATCH_EN, 32'h0);
		samp(20'h0ABCD, 0, 0, 0, 0, 0, 0, 0);
	endtask : t_swi_match
	task t_nmi;
		nmi_n <= 1'b0;
		repeat (12) @(posedge clk);
		nmi_n <= 1'b1;
		repeat (12) @(posedge clk);
		samp(20'h00500, 0, 0, 0, 0, 0, 0, 0);
		wr(OFS_PMODE2, 32'h1);
		nmi_n <= 1'b0;
		repeat (2) @(posedge clk);
		nmi_n <= 1'b1;
		repeat (12) @(posedge clk);
		samp(20'h00504, 0, 0, 0, 0, 0, 0, 0);
		nmi_n <= 1'b0;
		repeat (14) @(posedge clk);
		samp(20'h00508, 0, 0, 0, 1, KIND_NMI, VEC_NMI, 3'd7);
		nmi_n <= 1'b1;
		repeat (14) @(posedge clk);
	endtask : t_nmi
	task t_shared;
		ipc_cpu_model_inst.do_return_from_irq_instr(1'b0, 3'd0);
		wdt <= 1'b1;
		@(posedge clk);
		wdt <= 1'b0;
		samp(20'h00600, 0, 0, 0, 1, KIND_SHARED, VEC_SHARED, 3'd7);
		rd(OFS_SPECIAL, 32'h1);
		{osc, volt} <= 2'b11;
		@(posedge clk);
		{osc, volt} <= 2'b00;
		rd(OFS_SPECIAL, 32'h7);
		wr(OFS_SPECIAL, 32'h0);
		rd(OFS_SPECIAL, 32'h0);
	endtask : t_shared
	task t_key;
		wr(OFS_KEYDIR, 32'h0);
		key_n <= 4'hE;
		wakes(1);
		rd(OFS_REQ, 32'h40);
		wr(OFS_REQ, 32'h0);
		key_n <= 4'hC;
		wakes(0);
		rd(OFS_REQ, 32'h0);
		key_n <= 4'hF;
		repeat (4) @(posedge clk);
		wr(OFS_KEYDIR, 32'h4);
		key_n <= 4'hB;
		wakes(0);
		key_n <= 4'hF;
	endtask : t_key
	// ------------------------------------------------------------
	// Clock, hang limit and main sequence
	// ------------------------------------------------------------
	initial begin
		clk = 1'b0;
		forever #2 clk = ~clk;
	end
	initial begin
		repeat (50000) @(posedge clk);
		miscompares++;
		close_out();
	end
	initial begin
		{rst, nmi_n, key_n} = 6'h3F;
		{psel, pen, pwr, paddr, pwdata, ext, periph, wdt, osc, volt} = 52'h0;
		repeat (12) @(posedge clk);
		rst <= 1'b0;
		@(posedge clk);
		samp(20'h00100, 0, 1, 6'h05, 0, 0, 0, 0);
		rd(OFS_ISP, 32'h0);
		rd(OFS_USP, 32'h0);
		rd(8'h3C, 32'h0);
		`CHK("slverr", 1'b1, e)
		t_mask();
		t_swi_match();
		t_nmi();
		t_shared();
		t_key();
		close_out();
	end
endmodule : testbench
